//--- hdl/flash_cmd_regs.vh
// Opcodes, field positions, bit counts and status constants of the flash command engine.
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

`define OP_PAGE_RD_A 8'h52
`define OP_PAGE_RD_B 8'hd2
`define OP_BURST_RD_A 8'h68
`define OP_BURST_RD_B 8'he8
`define OP_BUF1_RD_A 8'h54
`define OP_BUF1_RD_B 8'hd4
`define OP_BUF2_RD_A 8'h56
`define OP_BUF2_RD_B 8'hd6
`define OP_STATUS_A 8'h57
`define OP_STATUS_B 8'hd7
`define OP_BUF1_WR 8'h84
`define OP_BUF2_WR 8'h87
`define OP_PGM_ERASE1 8'h83
`define OP_PGM_ERASE2 8'h86
`define OP_PGM_PLAIN1 8'h88
`define OP_PGM_PLAIN2 8'h89
`define OP_PAGE_ERASE 8'h81
`define OP_BLOCK_ERASE 8'h50

`define BIT_OPC_LAST 7'd7
`define BIT_ADDR_LAST 7'd31
`define BIT_HDR 7'd32
`define BIT_SAT 7'd127
`define START_PAGE_RD 7'd64
`define START_BUF_RD 7'd40
`define START_STATUS 7'd8

`define PAGE_F 20:9
`define BYTE_F 8:0
`define BLOCK_F 20:12
`define BLOCK_PAGE_FIRST 3'h0
`define BLOCK_PAGE_LAST 3'h7
`define PAGE_BYTE_LAST 9'd263
`define ERASED_BYTE 8'hff

// The density code value is arbitrary.
`define DENSITY_CODE 3'b011
`define COMPARE_RESET 1'b0
`define STATUS_RSVD 3'b000

`endif

//--- hdl/page_buffer_mem.v
// One page-sized SRAM buffer: one write port and two registered read ports.
`timescale 1ns/1ns
module page_buffer_mem #(
  parameter DATA_W = 8,
  parameter ADDR_W = 9,
  parameter DEPTH = 264
) (
  input wire clk,
  input wire we,
  input wire [ADDR_W-1:0] waddr,
  input wire [DATA_W-1:0] wdata,
  input wire [ADDR_W-1:0] raddr_a,
  output reg [DATA_W-1:0] rdata_a,
  input wire [ADDR_W-1:0] raddr_b,
  output reg [DATA_W-1:0] rdata_b
);
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  localparam [ADDR_W-1:0] LAST_ADDR = DEPTH[ADDR_W-1:0] - {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [ADDR_W-1:0] ra_a = (raddr_a > LAST_ADDR) ? LAST_ADDR : raddr_a;
  wire [ADDR_W-1:0] ra_b = (raddr_b > LAST_ADDR) ? LAST_ADDR : raddr_b;

  // Addresses past the last byte write nowhere and read the last word.
  always @(posedge clk) begin
    if (we && waddr <= LAST_ADDR) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[ra_a];
    rdata_b <= mem[ra_b];
  end
endmodule

//--- hdl/flash_command_engine.v
// Serial command engine of a page-organised flash with two page buffers.
// How it works
// - Chip select rising ends any read and releases the serial output.
// - Array reads fetch straight from the array, buffers untouched.
// - Page read: 52h/D2h, 24 address bits, 32 dummy bits, then data.
// - Array address is 3 reserved, 12 page, 9 byte bits.
// - Page read wraps from last byte to first byte of same page.
// - Buffer read: 54h/D4h selects buffer 1, 56h/D6h buffer 2.
// - Buffer read: 15 dummy, 9 address, 8 dummy bits, then data.
// - Buffer read wraps from last byte to first byte of buffer.
// - Status read 57h/D7h repeats eight fresh status bits, MSB first.
// - Status bit 7 is 1 when ready, 0 while busy.
// - With clock stopped after bit 7, output follows live ready flag.
// - Ready reads busy during every array program or erase operation.
// - Status bit 6 is fixed at the compare reset value, 0; no compare is made.
// - Bits 5..3 give a fixed density code; bits 2..0 reserved.
// - Buffer write 84h/87h stores bytes from address, wrapping, until deselect.
// - 83h/86h erases then programs the page from a buffer at deselect.
// - 88h/89h programs the page without erase at deselect.
// - 81h erases the addressed page to ones at deselect.
// - 50h erases the addressed block of eight pages at deselect.
// - Inputs sampled on clock rising edge, outputs driven on falling.
// - Opcodes, addresses and data travel most significant bit first.
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"
module flash_command_engine #(
  parameter ADDR_W = 21,
  parameter DATA_W = 8
) (
  input wire ref_clk,
  input wire arst_n,
  input wire cs_n,
  input wire sck,
  input wire si,
  output reg so,
  output reg so_oe,
  output reg ready,
  output reg arr_rd_req,
  output reg [ADDR_W-1:0] arr_rd_addr,
  input wire [DATA_W-1:0] arr_rd_data,
  input wire arr_rd_valid,
  output reg arr_wr_valid,
  output reg [ADDR_W-1:0] arr_wr_addr,
  output reg [DATA_W-1:0] arr_wr_data,
  input wire arr_wr_ready
);
  localparam S_IDLE = 3'd0;
  localparam S_ERASE = 3'd1;
  localparam S_PADDR = 3'd2;
  localparam S_PPUSH = 3'd3;
  localparam S_DRAIN = 3'd4;
  localparam FIFO_W = ADDR_W + DATA_W;

  function [8:0] next_byte_addr;
    input [8:0] a;
    begin
      next_byte_addr = (a == `PAGE_BYTE_LAST) ? 9'h000 : a + 9'd1;
    end
  endfunction

  // Pin synchronisers; logic reads the second stage, and its delayed copy for edge detection.
  reg [1:0] cs_sync, sck_sync, si_sync;
  reg cs_d, sck_d;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync <= 2'b11;
      sck_sync <= 2'b00;
      si_sync <= 2'b00;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n};
      sck_sync <= {sck_sync[0], sck};
      si_sync <= {si_sync[0], si};
      cs_d <= cs_sync[1];
      sck_d <= sck_sync[1];
    end
  end
  wire cs_high = cs_sync[1];
  wire si_s = si_sync[1];
  wire cs_rise = cs_high & ~cs_d;
  wire sck_rise = sck_sync[1] & ~sck_d;
  wire sck_fall = ~sck_sync[1] & sck_d;

  reg [7:0] opcode, out_shift, prefetch, bw_wdata;
  reg [6:0] bit_cnt;
  reg [2:0] bit_in_byte, out_cnt, state;
  reg [22:0] shift_in;
  reg [23:0] addr;
  reg [11:0] rd_page, op_page, op_page_last, op_pg;
  reg [8:0] rd_byte, bw_ptr, bw_waddr, op_byte;
  reg fetch_go, buf_cap, bw_we, op_prog, op_buf2, fifo_v1;
  reg [FIFO_W-1:0] fifo_e1;

  wire is_page_rd = opcode == `OP_PAGE_RD_A || opcode == `OP_PAGE_RD_B;
  wire is_burst = opcode == `OP_BURST_RD_A || opcode == `OP_BURST_RD_B;
  wire is_buf2_rd = opcode == `OP_BUF2_RD_A || opcode == `OP_BUF2_RD_B;
  wire is_buf_rd = is_buf2_rd || opcode == `OP_BUF1_RD_A || opcode == `OP_BUF1_RD_B;
  wire is_status = opcode == `OP_STATUS_A || opcode == `OP_STATUS_B;
  wire is_buf_wr = opcode == `OP_BUF1_WR || opcode == `OP_BUF2_WR;
  wire from_array = is_page_rd | is_burst;
  wire rd_mode = from_array | is_buf_rd | is_status;
  wire [6:0] data_start = from_array ? `START_PAGE_RD : is_buf_rd ? `START_BUF_RD : `START_STATUS;
  wire busy = state != S_IDLE;
  wire [7:0] status_now = {~busy, `COMPARE_RESET, `DENSITY_CODE, `STATUS_RSVD};
  wire [7:0] cur_byte = is_status ? status_now : prefetch;

  // Serial side: header capture, buffer write stream and output shifter.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      opcode <= 8'h00;
      bit_cnt <= 7'd0;
      bit_in_byte <= 3'd0;
      shift_in <= 23'h000000;
      addr <= 24'h000000;
      rd_page <= 12'h000;
      rd_byte <= 9'h000;
      fetch_go <= 1'b0;
      out_cnt <= 3'd0;
      out_shift <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
      bw_we <= 1'b0;
      bw_ptr <= 9'h000;
      bw_waddr <= 9'h000;
      bw_wdata <= 8'h00;
    end else begin
      fetch_go <= 1'b0;
      bw_we <= 1'b0;
      if (cs_high) begin
        // Deselect ends every read and floats the output.
        opcode <= 8'h00;
        bit_cnt <= 7'd0;
        bit_in_byte <= 3'd0;
        out_cnt <= 3'd0;
        so_oe <= 1'b0;
        so <= 1'b0;
      end else begin
        if (sck_rise) begin
          // Inputs are taken on the rising edge, most significant bit first.
          shift_in <= {shift_in[21:0], si_s};
          bit_in_byte <= bit_in_byte + 3'd1;
          if (bit_cnt != `BIT_SAT) begin
            bit_cnt <= bit_cnt + 7'd1;
          end
          if (bit_cnt == `BIT_OPC_LAST) begin
            opcode <= {shift_in[6:0], si_s};
          end
          if (bit_cnt == `BIT_ADDR_LAST) begin
            // The top three address bits are kept but never decoded.
            addr <= {shift_in, si_s};
            rd_page <= shift_in[19:8];
            rd_byte <= {shift_in[7:0], si_s};
            bw_ptr <= {shift_in[7:0], si_s};
            fetch_go <= 1'b1;
          end
          if (is_buf_wr && bit_cnt >= `BIT_HDR && bit_in_byte == 3'd7) begin
            // Whole bytes only; a partial byte at deselect is dropped.
            bw_we <= 1'b1;
            bw_waddr <= bw_ptr;
            bw_wdata <= {shift_in[6:0], si_s};
            bw_ptr <= next_byte_addr(bw_ptr);
          end
        end
        if (sck_fall && rd_mode && bit_cnt >= data_start) begin
          // Data leaves on the falling edge once the dummy bits are in.
          so_oe <= 1'b1;
          out_cnt <= out_cnt + 3'd1;
          if (out_cnt == 3'd0) begin
            so <= cur_byte[7];
            out_shift <= {cur_byte[6:0], 1'b0};
            if (!is_status) begin
              rd_byte <= next_byte_addr(rd_byte);
              fetch_go <= 1'b1;
              if (is_burst && rd_byte == `PAGE_BYTE_LAST) begin
                // Burst read moves on to the next page and wraps at the array end.
                // The host gives the boundary gap, so no stall is built here.
                rd_page <= rd_page + 12'd1;
              end
            end
          end else begin
            so <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
          end
        end else if (is_status && so_oe && out_cnt == 3'd1) begin
          so <= ~busy;
        end
      end
    end
  end

  // Prefetch of the next read byte, from the array or a buffer.
  wire [7:0] buf1_qa, buf2_qa, buf1_qb, buf2_qb;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arr_rd_req <= 1'b0;
      arr_rd_addr <= {ADDR_W{1'b0}};
      buf_cap <= 1'b0;
      prefetch <= 8'h00;
    end else begin
      arr_rd_req <= 1'b0;
      buf_cap <= 1'b0;
      if (fetch_go && from_array) begin
        arr_rd_req <= 1'b1;
        arr_rd_addr <= {rd_page, rd_byte};
      end else if (fetch_go) begin
        buf_cap <= 1'b1;
      end
      if (buf_cap) begin
        prefetch <= is_buf2_rd ? buf2_qa : buf1_qa;
      end else if (arr_rd_valid && from_array) begin
        prefetch <= arr_rd_data;
      end
    end
  end

  // Buffer writes go only to the buffer named by the opcode.
  wire bw_sel2 = opcode == `OP_BUF2_WR;

  page_buffer_mem #(.DATA_W(8), .ADDR_W(9), .DEPTH(264)) buf1 (
    .clk(ref_clk), .we(bw_we & ~bw_sel2), .waddr(bw_waddr), .wdata(bw_wdata),
    .raddr_a(rd_byte), .rdata_a(buf1_qa), .raddr_b(op_byte), .rdata_b(buf1_qb)
  );
  page_buffer_mem #(.DATA_W(8), .ADDR_W(9), .DEPTH(264)) buf2 (
    .clk(ref_clk), .we(bw_we & bw_sel2), .waddr(bw_waddr), .wdata(bw_wdata),
    .raddr_a(rd_byte), .rdata_a(buf2_qa), .raddr_b(op_byte), .rdata_b(buf2_qb)
  );

  // Two-entry buffer toward the array; a stalled array holds the sequencer.
  wire fifo_in_ready = ~fifo_v1;
  wire fifo_push = (state == S_ERASE || state == S_PPUSH) && fifo_in_ready;
  wire [7:0] push_data = (state == S_ERASE) ? `ERASED_BYTE : (op_buf2 ? buf2_qb : buf1_qb);
  wire [FIFO_W-1:0] push_word = {op_pg, op_byte, push_data};
  wire fifo_pop = arr_wr_valid & arr_wr_ready;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arr_wr_valid <= 1'b0;
      arr_wr_addr <= {ADDR_W{1'b0}};
      arr_wr_data <= {DATA_W{1'b0}};
      fifo_e1 <= {FIFO_W{1'b0}};
      fifo_v1 <= 1'b0;
    end else if (fifo_pop && fifo_v1) begin
      {arr_wr_addr, arr_wr_data} <= fifo_e1;
      fifo_v1 <= fifo_push;
      if (fifo_push) begin
        fifo_e1 <= push_word;
      end
    end else if (fifo_pop || !arr_wr_valid) begin
      arr_wr_valid <= fifo_push;
      if (fifo_push) begin
        {arr_wr_addr, arr_wr_data} <= push_word;
      end
    end else if (fifo_push) begin
      fifo_e1 <= push_word;
      fifo_v1 <= 1'b1;
    end
  end

  // Array sequencer, launched by deselect after a complete header.
  wire hdr_done = bit_cnt >= `BIT_HDR;
  wire go_erase_pgm = opcode == `OP_PGM_ERASE1 || opcode == `OP_PGM_ERASE2;
  wire go_plain_pgm = opcode == `OP_PGM_PLAIN1 || opcode == `OP_PGM_PLAIN2;
  wire go_buf2 = opcode == `OP_PGM_ERASE2 || opcode == `OP_PGM_PLAIN2;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      op_page <= 12'h000;
      op_page_last <= 12'h000;
      op_pg <= 12'h000;
      op_byte <= 9'h000;
      op_prog <= 1'b0;
      op_buf2 <= 1'b0;
      ready <= 1'b1;
    end else begin
      ready <= ~busy;
      case (state)
        S_IDLE: begin
          // A new array command while busy is ignored.
          if (cs_rise && hdr_done) begin
            op_page <= addr[`PAGE_F];
            op_pg <= addr[`PAGE_F];
            op_page_last <= addr[`PAGE_F];
            op_byte <= 9'h000;
            op_buf2 <= go_buf2;
            op_prog <= go_erase_pgm;
            if (go_erase_pgm || opcode == `OP_PAGE_ERASE) begin
              state <= S_ERASE;
            end else if (opcode == `OP_BLOCK_ERASE) begin
              op_pg <= {addr[`BLOCK_F], `BLOCK_PAGE_FIRST};
              op_page_last <= {addr[`BLOCK_F], `BLOCK_PAGE_LAST};
              state <= S_ERASE;
            end else if (go_plain_pgm) begin
              state <= S_PADDR;
            end
          end
        end
        S_ERASE: begin
          if (fifo_push) begin
            op_byte <= next_byte_addr(op_byte);
            if (op_byte == `PAGE_BYTE_LAST) begin
              op_pg <= op_pg + 12'd1;
              if (op_pg == op_page_last) begin
                op_pg <= op_page;
                state <= op_prog ? S_PADDR : S_DRAIN;
              end
            end
          end
        end
        S_PADDR: begin
          // One cycle for the buffer's registered read to settle.
          state <= S_PPUSH;
        end
        S_PPUSH: begin
          if (fifo_push) begin
            op_byte <= next_byte_addr(op_byte);
            state <= (op_byte == `PAGE_BYTE_LAST) ? S_DRAIN : S_PADDR;
          end
        end
        S_DRAIN: begin
          // Busy lasts until the array has taken every word.
          if (!arr_wr_valid && !fifo_v1) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

//--- test/flash_command_engine_assertions.sv
// Port-level assertions for the flash command engine, bound to its top module.
`timescale 1ns/1ns
module flash_cmd_checker #(
  parameter ADDR_W = 21,
  parameter DATA_W = 8
) (
  input wire ref_clk,
  input wire arst_n,
  input wire cs_n,
  input wire so_oe,
  input wire ready,
  input wire arr_rd_req,
  input wire arr_wr_valid,
  input wire [ADDR_W-1:0] arr_wr_addr,
  input wire [DATA_W-1:0] arr_wr_data,
  input wire arr_wr_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
    else $error("so_oe still on after deselect");
  a_oe_deselected: assert property (cs_n [*6] |-> !so_oe)
    else $error("so_oe on while deselected");
  a_no_fetch_idle: assert property (cs_n [*8] |-> !arr_rd_req)
    else $error("array fetch while deselected");
  a_fetch_pulse: assert property (arr_rd_req |=> !arr_rd_req)
    else $error("fetch request longer than one cycle");
  a_busy_on_write: assert property (arr_wr_valid |-> !ready)
    else $error("ready high while array words pending");
  a_write_hold: assert property (arr_wr_valid && !arr_wr_ready |=>
    arr_wr_valid && $stable(arr_wr_addr) && $stable(arr_wr_data))
    else $error("array word changed before acceptance");
  a_write_in_page: assert property (arr_wr_valid |-> arr_wr_addr[8:0] <= 9'd263)
    else $error("array word beyond page end");
  a_busy_starts_write: assert property ($fell(ready) |-> ##[0:8] arr_wr_valid)
    else $error("busy without array words");
  cover property ($fell(ready));
  cover property ($rose(so_oe));
  cover property (arr_wr_valid && !arr_wr_ready);
endmodule
bind flash_command_engine flash_cmd_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .so_oe(so_oe), .ready(ready),
  .arr_rd_req(arr_rd_req), .arr_wr_valid(arr_wr_valid), .arr_wr_addr(arr_wr_addr),
  .arr_wr_data(arr_wr_data), .arr_wr_ready(arr_wr_ready));

//--- test/flash_array_model.sv
// Behavioural flash array answering the engine's fetch and store ports.
`timescale 1ns/1ns
module flash_array_model #(
  parameter LAT = 3
) (
  input wire ref_clk,
  input wire arr_rd_req,
  input wire [20:0] arr_rd_addr,
  output logic [7:0] arr_rd_data,
  output logic arr_rd_valid,
  input wire arr_wr_valid,
  input wire [20:0] arr_wr_addr,
  input wire [7:0] arr_wr_data,
  output logic arr_wr_ready
);
  logic [7:0] mem [int];
  logic [20:0] ra;
  int lat = 0;
  int cnt = 0;
  initial begin
    arr_rd_valid = 1'b0;
    arr_rd_data = 8'h00;
    arr_wr_ready = 1'b0;
  end
  // Cells never written read as ones, the erased state. Ready stalls half the
  // time so that busy lasts longer than the plain drain.
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    arr_wr_ready <= cnt[1];
    arr_rd_valid <= 1'b0;
    arr_rd_data <= ~arr_rd_data;
    if (arr_wr_valid && arr_wr_ready) mem[arr_wr_addr] = arr_wr_data;
    if (arr_rd_req) begin
      ra <= arr_rd_addr;
      lat <= LAT;
    end else if (lat == 1) begin
      arr_rd_valid <= 1'b1;
      arr_rd_data <= mem.exists(ra) ? mem[ra] : 8'hff;
      lat <= 0;
    end else if (lat > 0) begin
      lat <= lat - 1;
    end
  end
endmodule

//--- test/serial_flash_command_engine_tb.sv
// Self-checking bench of the flash command engine over its serial link.
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"
module serial_flash_command_engine_tb;
  localparam logic [7:0] ST = {1'b1, `COMPARE_RESET, `DENSITY_CODE, `STATUS_RSVD};
  // Host pause before the first clock after a page end, in ref_clk cycles; a plain default.
  localparam int boundary_clock_gap = 16;
  typedef struct packed {logic [7:0] op; logic [8:0] a; logic [7:0] s; logic [23:0] e;} row_t;
  row_t rows [6] = '{
    '{`OP_STATUS_A, 9'h000, 8'h00, {ST, ST, ST}},
    '{`OP_STATUS_B, 9'h000, 8'h00, {ST, ST, ST}},
    '{`OP_BUF1_RD_A, 9'h000, 8'h10, 24'h101112},
    '{`OP_BUF2_RD_A, 9'h005, 8'h20, 24'h202122},
    '{`OP_BUF1_RD_B, 9'h106, 8'h30, 24'h303132},
    '{`OP_BUF2_RD_B, 9'h107, 8'h40, 24'h404142}};
  logic ref_clk, arst_n, cs_n, sck, si;
  wire so, so_oe, ready, rd_req, rd_valid, wr_valid, wr_ready;
  wire [20:0] rd_addr, wr_addr;
  wire [7:0] rd_data, wr_data;
  logic [7:0] buf_sh [2][264];
  logic [7:0] rq [4];
  logic [7:0] rx;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  flash_command_engine dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .so(so), .so_oe(so_oe), .ready(ready), .arr_rd_req(rd_req),
    .arr_rd_addr(rd_addr), .arr_rd_data(rd_data), .arr_rd_valid(rd_valid),
    .arr_wr_valid(wr_valid), .arr_wr_addr(wr_addr), .arr_wr_data(wr_data),
    .arr_wr_ready(wr_ready));
  flash_array_model arr_u (.ref_clk(ref_clk), .arr_rd_req(rd_req), .arr_rd_addr(rd_addr),
    .arr_rd_data(rd_data), .arr_rd_valid(rd_valid), .arr_wr_valid(wr_valid),
    .arr_wr_addr(wr_addr), .arr_wr_data(wr_data), .arr_wr_ready(wr_ready));
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // Mode 0 framing: clock rests low, so is sampled late in the low phase.
  task xbyte(input logic [7:0] tx, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk);
      sck <= 1'b0;
      si <= tx[i];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      got[i] = so;
      @(posedge ref_clk);
      sck <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task sel;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task open_cmd(input logic [7:0] op, input logic [23:0] a);
    sel();
    xbyte(op, rx);
    for (int k = 2; k >= 0; k--) xbyte(a[k*8 +: 8], rx);
  endtask
  task close_cmd;
    @(posedge ref_clk);
    sck <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("so_oe", 8'h00, {7'h0, so_oe});
  endtask
  task rd(input logic [7:0] op, input logic [23:0] a, input int dum, input int n);
    open_cmd(op, a);
    repeat (dum) xbyte(8'hff, rx);
    for (int k = 0; k < n; k++) xbyte(8'h00, rq[k]);
    close_cmd();
  endtask
  task bwr(input int b, input logic [8:0] a, input int n, input logic [7:0] s);
    open_cmd(b ? `OP_BUF2_WR : `OP_BUF1_WR, {15'h7fff, a});
    for (int k = 0; k < n; k++) begin
      xbyte(s + k[7:0], rx);
      buf_sh[b][(a + k) % 264] = s + k[7:0];
    end
    close_cmd();
  endtask
  task launch(input logic [7:0] op, input logic [23:0] a);
    open_cmd(op, a);
    close_cmd();
  endtask
  task wait_ready;
    for (int t = 0; t < 20000 && ready !== 1'b1; t++) @(posedge ref_clk);
    chk("ready", 8'h01, {7'h0, ready});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      $display("BAD run length exp finished got hung");
      end_sim();
    end
  end
  initial begin
    arst_n = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    chk("reset ready", 8'h01, {7'h0, ready});
    for (int r = 0; r < 6; r++) begin
      if (rows[r].op == `OP_STATUS_A || rows[r].op == `OP_STATUS_B) begin
        sel();
        xbyte(rows[r].op, rx);
        for (int k = 0; k < 3; k++) xbyte(8'h00, rq[k]);
        close_cmd();
      end else begin
        bwr(rows[r].op[1], rows[r].a, 3, rows[r].s);
        rd(rows[r].op, {15'h7fff, rows[r].a}, 1, 3);
      end
      for (int k = 0; k < 3; k++) chk("row", rows[r].e[23-8*k -: 8], rq[k]);
      $display("row %0d done", r);
    end
    // The poll after the launch leaves the clock stopped after bit 7 to watch ready live.
    launch(`OP_PGM_ERASE1, {3'b111, 12'd8, 9'h1ff});
    sel();
    xbyte(`OP_STATUS_A, rx);
    @(posedge ref_clk);
    sck <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("live busy", 8'h00, {7'h0, so});
    for (int t = 0; t < 20000 && so !== 1'b1; t++) @(posedge ref_clk);
    chk("live ready", 8'h01, {7'h0, so});
    close_cmd();
    rd(`OP_PAGE_RD_A, {3'b111, 12'd8, 9'd262}, 4, 3);
    for (int k = 0; k < 3; k++) chk("page wrap", buf_sh[0][(262 + k) % 264], rq[k]);
    open_cmd(`OP_BURST_RD_A, {3'b111, 12'd8, 9'd262});
    repeat (4) xbyte(8'hff, rx);
    xbyte(8'h00, rq[0]);
    xbyte(8'h00, rq[1]);
    repeat (boundary_clock_gap) @(posedge ref_clk);
    xbyte(8'h00, rq[2]);
    close_cmd();
    chk("burst byte 262", buf_sh[0][262], rq[0]);
    chk("burst byte 263", buf_sh[0][263], rq[1]);
    chk("burst next page", `ERASED_BYTE, rq[2]);
    $display("burst read done");
    $display("program with erase done");
    launch(`OP_PAGE_ERASE, {3'b111, 12'd5, 9'h1ff});
    wait_ready();
    rd(`OP_PAGE_RD_A, {3'b111, 12'd5, 9'd5}, 4, 1);
    chk("page erased", `ERASED_BYTE, rq[0]);
    launch(`OP_PGM_PLAIN2, {3'b111, 12'd5, 9'h1ff});
    wait_ready();
    rd(`OP_PAGE_RD_B, {3'b111, 12'd5, 9'd5}, 4, 3);
    for (int k = 0; k < 3; k++) chk("plain prog", buf_sh[1][5 + k], rq[k]);
    $display("erase and plain program done");
    launch(`OP_BLOCK_ERASE, {3'b111, 9'd0, 12'hfff});
    wait_ready();
    rd(`OP_PAGE_RD_B, {3'b111, 12'd5, 9'd5}, 4, 1);
    chk("block erased", `ERASED_BYTE, rq[0]);
    rd(`OP_PAGE_RD_A, {3'b111, 12'd8, 9'd262}, 4, 1);
    chk("next block kept", buf_sh[0][262], rq[0]);
    rd(`OP_BUF2_RD_A, {15'h0, 9'd5}, 1, 1);
    chk("buffer kept", buf_sh[1][5], rq[0]);
    $display("block erase done");
    // Reset in the middle of an erase must leave the engine idle and selectable.
    launch(`OP_PAGE_ERASE, {3'b111, 12'd20, 9'h000});
    chk("erase busy", 8'h00, {7'h0, ready});
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    chk("midrun ready", 8'h01, {7'h0, ready});
    chk("midrun so_oe", 8'h00, {7'h0, so_oe});
    sel();
    xbyte(`OP_STATUS_B, rx);
    xbyte(8'h00, rq[0]);
    close_cmd();
    chk("status after reset", ST, rq[0]);
    $display("mid-run reset done");
    end_sim();
  end
endmodule
